// *** pkg/ddrpr_defines.vh ***
// constants for the ddr2 precharge, refresh and power-down block
// Notes on behaviour
// - A10 high on read/write closes bank after burst
// - read autoprecharge starts AL+BL/2 edges after command
// - autoprecharge waits until row active minimum met
// - precharge period counts from exact read-to-precharge end
// - internal precharge two clocks after last prefetch
// - write autoprecharge after burst plus write recovery
// - refresh only with all banks idle
// - refresh uses internal address counter
// - cke low with nop enters power-down
// - idle gives precharge power-down, dll off unless fast-exit active power-down
// - cke high with nop exits, then exit latency
`ifndef DDRPR_DEFINES_VH
`define DDRPR_DEFINES_VH

// register word indices (byte address = 4 * index)
`define DDRPR_IDX_CFG 6'h00
`define DDRPR_IDX_TIM 6'h01
`define DDRPR_IDX_STAT 6'h02
`define DDRPR_IDX_REF 6'h03
`define DDRPR_IDX_ERR 6'h04

// cfg fields
`define DDRPR_CFG_AL 2:0
`define DDRPR_CFG_CL 5:3
`define DDRPR_CFG_BL8 6
`define DDRPR_CFG_WR 9:7
`define DDRPR_CFG_SLOW 10
`define DDRPR_CFG_RST 11'h19c

// tim fields, all but exit latency in 4 ns clk cycles
`define DDRPR_TIM_RAS 7:0
`define DDRPR_TIM_RDPC 15:8
`define DDRPR_TIM_RP 23:16
`define DDRPR_TIM_XP 27:24
`define DDRPR_TIM_RST 28'h2040210

// error bits
`define DDRPR_ERR_REF 0
`define DDRPR_ERR_CKE 1
`define DDRPR_ERR_XP 2

`endif

// *** design/ddrpr_bank.v ***
// one bank: open/closed tracking and autoprecharge timing
`timescale 1ns/1ps
module ddrpr_bank (
  input wire clk,
  input wire nrst,
  input wire ck_rise,
  input wire act,
  input wire rd,
  input wire wr,
  input wire ap,
  input wire pre,
  input wire pre_all,
  input wire [4:0] pref_dly,
  input wire [4:0] rd_ap_dly,
  input wire [4:0] wr_ap_dly,
  input wire [7:0] tras,
  input wire [7:0] trtp,
  input wire [7:0] trp,
  input wire [7:0] ck_per,
  output wire open_o,
  output wire busy_o
);
  // one-hot bank states
  localparam S_IDLE = 4'b0001;
  localparam S_ACT = 4'b0010;
  localparam S_APW = 4'b0100;
  localparam S_PRE = 4'b1000;

  reg [3:0] state_reg; // bank state
  reg [4:0] ap_cnt_reg; // ck edges to nominal autoprecharge
  reg ap_wr_reg; // pending autoprecharge came from a write
  reg [4:0] pf_cnt_reg; // ck edges to last prefetch
  reg pf_arm_reg; // last prefetch still ahead
  reg [7:0] ras_cnt_reg; // clk cycles of row active left
  reg [7:0] rdpc_cnt_reg; // clk cycles of read-to-precharge left
  reg [8:0] rp_cnt_reg; // clk cycles of precharge left
  wire ap_go;

  // precharge start is checked every clk, not only on ck edges,
  // so a late read-to-precharge end starts the period exactly
  assign ap_go = (ap_cnt_reg == 5'h00) && (ras_cnt_reg == 8'h00) &&
    (ap_wr_reg || (!pf_arm_reg && rdpc_cnt_reg == 8'h00));

  assign open_o = state_reg[1] | state_reg[2];
  assign busy_o = state_reg[2] | state_reg[3];

  // row active and read-to-precharge timers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ras_cnt_reg <= 8'h00;
      rdpc_cnt_reg <= 8'h00;
      pf_cnt_reg <= 5'h00;
      pf_arm_reg <= 1'b0;
    end else begin
      if (act)
        ras_cnt_reg <= tras;
      else if (ras_cnt_reg != 8'h00)
        ras_cnt_reg <= ras_cnt_reg - 8'h01;
      // read-to-precharge is counted from the last 4-bit prefetch
      if (rd) begin
        if (pref_dly == 5'h00) begin
          rdpc_cnt_reg <= trtp;
          pf_arm_reg <= 1'b0;
        end else begin
          pf_cnt_reg <= pref_dly;
          pf_arm_reg <= 1'b1;
        end
      end else if (pf_arm_reg && ck_rise) begin
        pf_cnt_reg <= pf_cnt_reg - 5'h01;
        if (pf_cnt_reg == 5'h01) begin
          rdpc_cnt_reg <= trtp;
          pf_arm_reg <= 1'b0;
        end
      end else if (rdpc_cnt_reg != 8'h00) begin
        rdpc_cnt_reg <= rdpc_cnt_reg - 8'h01;
      end
    end
  end

  // bank state machine
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      ap_cnt_reg <= 5'h00;
      ap_wr_reg <= 1'b0;
      rp_cnt_reg <= 9'h000;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (act)
            state_reg <= S_ACT;
        end
        S_ACT: begin
          if (pre_all) begin
            state_reg <= S_PRE;
            rp_cnt_reg <= {1'b0, trp} + {1'b0, ck_per};
          end else if (pre) begin
            state_reg <= S_PRE;
            rp_cnt_reg <= {1'b0, trp};
          end else if ((rd || wr) && ap) begin
            // a10 high: close the row after the burst
            state_reg <= S_APW;
            ap_cnt_reg <= wr ? wr_ap_dly : rd_ap_dly;
            ap_wr_reg <= wr;
          end
        end
        S_APW: begin
          if (ap_go) begin
            state_reg <= S_PRE;
            rp_cnt_reg <= {1'b0, trp};
          end else if (ck_rise && ap_cnt_reg != 5'h00) begin
            ap_cnt_reg <= ap_cnt_reg - 5'h01;
          end
        end
        S_PRE: begin
          // a later all-bank precharge restarts the period
          if (pre_all)
            rp_cnt_reg <= {1'b0, trp} + {1'b0, ck_per};
          else if (rp_cnt_reg <= 9'h001)
            state_reg <= S_IDLE;
          else
            rp_cnt_reg <= rp_cnt_reg - 9'h001;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// *** design/ddrpr_top.v ***
// ddr2 device side: bank closing, refresh and power-down with wishbone regs
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "ddrpr_defines.vh"
module ddrpr_top #(
  parameter RW = 16
) (
  input wire clk,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ck,
  input wire cke,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire a10,
  input wire [2:0] ba,
  output reg [7:0] bank_open,
  output reg dll_on,
  output reg pd_active,
  output reg cmd_ready
);
  // one-hot power states
  localparam P_RUN = 4'b0001;
  localparam P_PPD = 4'b0010;
  localparam P_APF = 4'b0100;
  localparam P_APS = 4'b1000;

  // pin synchroniser; the second stage feeds all logic
  reg [9:0] pin_s1_reg;
  reg [9:0] pin_s2_reg;
  reg ck_s3_reg; // previous synced clock level for edge find
  wire ck_rise;
  wire cke_s;
  wire cs_s;
  wire ras_s;
  wire cas_s;
  wire we_s;
  wire a10_s;
  wire [2:0] ba_s;

  // registers
  reg [10:0] cfg_reg;
  reg [27:0] tim_reg;
  reg [2:0] err_reg;
  reg [RW-1:0] ref_row_reg; // internal refresh address
  reg [7:0] ck_per_reg; // measured ck period in clk cycles
  reg [7:0] per_cnt_reg;
  reg cke_prev_reg; // cke at previous ck edge
  reg [3:0] pstate_reg;
  reg [3:0] xp_cnt_reg; // exit latency left, ck edges
  reg [4:0] burst_cnt_reg; // read/write burst in progress

  // decoded commands, each but is_nop valid for one clk at a ck edge
  wire cmd_ok;
  wire is_nop;
  wire is_act;
  wire is_rd;
  wire is_wr;
  wire is_pre;
  wire is_ref;
  wire [7:0] bsel;
  wire [7:0] b_open;
  wire [7:0] b_busy;
  wire all_idle;

  // derived delays in ck edges
  wire [4:0] al5;
  wire [4:0] cl5;
  wire [4:0] wr5;
  wire [4:0] pref_dly;
  wire [4:0] rd_ap_dly;
  wire [4:0] wr_ap_dly;
  wire [4:0] burst_dly;

  // bus
  wire wb_req;
  wire [5:0] widx;
  wire [31:0] wmask;
  wire [31:0] stat_word;

  assign ck_rise = pin_s2_reg[9] & ~ck_s3_reg;
  assign cke_s = pin_s2_reg[8];
  assign cs_s = pin_s2_reg[7];
  assign ras_s = pin_s2_reg[6];
  assign cas_s = pin_s2_reg[5];
  assign we_s = pin_s2_reg[4];
  assign a10_s = pin_s2_reg[3];
  assign ba_s = pin_s2_reg[2:0];

  // commands only count with cke high at this and the last edge
  assign cmd_ok = ck_rise & cke_prev_reg & cke_s;
  assign is_nop = cs_s | (ras_s & cas_s & we_s);
  assign is_act = cmd_ok & ~cs_s & ~ras_s & cas_s & we_s;
  assign is_rd = cmd_ok & ~cs_s & ras_s & ~cas_s & we_s;
  assign is_wr = cmd_ok & ~cs_s & ras_s & ~cas_s & ~we_s;
  assign is_pre = cmd_ok & ~cs_s & ~ras_s & cas_s & ~we_s;
  assign is_ref = cmd_ok & ~cs_s & ~ras_s & ~cas_s & we_s;
  assign all_idle = ((b_open | b_busy) == 8'h00);

  assign al5 = {2'b00, cfg_reg[`DDRPR_CFG_AL]};
  assign cl5 = {2'b00, cfg_reg[`DDRPR_CFG_CL]};
  assign wr5 = {2'b00, cfg_reg[`DDRPR_CFG_WR]};
  // last prefetch: AL for burst of four, AL+2 for eight
  assign pref_dly = al5 + (cfg_reg[`DDRPR_CFG_BL8] ? 5'h02 : 5'h00);
  // nominal start is two edges after the last prefetch
  assign rd_ap_dly = pref_dly + 5'h02;
  // write latency AL+CL-1, burst BL/2, then write recovery
  assign wr_ap_dly = al5 + cl5 - 5'h01 +
    (cfg_reg[`DDRPR_CFG_BL8] ? 5'h04 : 5'h02) + wr5;
  assign burst_dly = al5 + cl5 +
    (cfg_reg[`DDRPR_CFG_BL8] ? 5'h04 : 5'h02);

  // one bank model per bank address
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bank
      assign bsel[gi] = (ba_s == gi);
      ddrpr_bank u_bank (
        .clk(clk),
        .nrst(nrst),
        .ck_rise(ck_rise),
        .act(is_act & bsel[gi]),
        .rd(is_rd & bsel[gi]),
        .wr(is_wr & bsel[gi]),
        .ap(a10_s),
        .pre(is_pre & ~a10_s & bsel[gi]),
        .pre_all(is_pre & a10_s),
        .pref_dly(pref_dly),
        .rd_ap_dly(rd_ap_dly),
        .wr_ap_dly(wr_ap_dly),
        .tras(tim_reg[`DDRPR_TIM_RAS]),
        .trtp(tim_reg[`DDRPR_TIM_RDPC]),
        .trp(tim_reg[`DDRPR_TIM_RP]),
        .ck_per(ck_per_reg),
        .open_o(b_open[gi]),
        .busy_o(b_busy[gi])
      );
    end
  endgenerate

  // synchroniser and clock edge history
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_reg <= 10'h000;
      pin_s2_reg <= 10'h000;
      ck_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {ck, cke, cs_n, ras_n, cas_n, we_n, a10, ba};
      pin_s2_reg <= pin_s1_reg;
      ck_s3_reg <= pin_s2_reg[9];
    end
  end

  // ck period measure; adds the extra clock to all-bank precharge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      per_cnt_reg <= 8'h00;
      ck_per_reg <= 8'h00;
    end else if (ck_rise) begin
      ck_per_reg <= per_cnt_reg + 8'h01;
      per_cnt_reg <= 8'h00;
    end else if (per_cnt_reg != 8'hff) begin
      per_cnt_reg <= per_cnt_reg + 8'h01;
    end
  end

  // burst tracker, blocks nothing but flags cke drops mid burst
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      burst_cnt_reg <= 5'h00;
    else if (is_rd | is_wr)
      burst_cnt_reg <= burst_dly;
    else if (ck_rise && burst_cnt_reg != 5'h00)
      burst_cnt_reg <= burst_cnt_reg - 5'h01;
  end

  // refresh row counter: no external address is used
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      ref_row_reg <= {RW{1'b0}};
    else if (is_ref && all_idle)
      ref_row_reg <= ref_row_reg + {{(RW-1){1'b0}}, 1'b1};
  end

  // power-down state machine, evaluated on ck edges
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pstate_reg <= P_RUN;
      cke_prev_reg <= 1'b0;
      xp_cnt_reg <= 4'h0;
    end else if (ck_rise) begin
      cke_prev_reg <= cke_s;
      if (xp_cnt_reg != 4'h0)
        xp_cnt_reg <= xp_cnt_reg - 4'h1;
      case (pstate_reg)
        P_RUN: begin
          // entry needs cke registered low with nop or deselect
          if (cke_prev_reg && !cke_s && is_nop) begin
            if (b_open == 8'h00)
              pstate_reg <= P_PPD;
            else if (cfg_reg[`DDRPR_CFG_SLOW])
              pstate_reg <= P_APS;
            else
              pstate_reg <= P_APF;
          end
        end
        P_PPD, P_APF, P_APS: begin
          if (!cke_prev_reg && cke_s && is_nop) begin
            pstate_reg <= P_RUN;
            xp_cnt_reg <= tim_reg[`DDRPR_TIM_XP];
          end
        end
        default: begin
          pstate_reg <= P_RUN;
        end
      endcase
    end
  end

  // registered status outputs
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank_open <= 8'h00;
      dll_on <= 1'b1;
      pd_active <= 1'b0;
      cmd_ready <= 1'b1;
    end else begin
      bank_open <= b_open;
      // dll runs only in normal mode and fast-exit active power-down
      dll_on <= pstate_reg[0] | pstate_reg[2];
      pd_active <= ~pstate_reg[0];
      cmd_ready <= pstate_reg[0] & (xp_cnt_reg == 4'h0);
    end
  end

  // wishbone classic slave: ack one cycle after the strobe,
  // write lands at the edge where the master sees ack
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign widx = wb_adr_i[7:2];
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign stat_word = {ck_per_reg, 3'h0, cmd_ready, dll_on,
    pstate_reg[3:1], b_busy, b_open};

  // ack and read data
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req && !wb_ack_o) begin
        case (widx)
          `DDRPR_IDX_CFG: wb_dat_o <= {21'h000000, cfg_reg};
          `DDRPR_IDX_TIM: wb_dat_o <= {4'h0, tim_reg};
          `DDRPR_IDX_STAT: wb_dat_o <= stat_word;
          `DDRPR_IDX_REF: wb_dat_o <= {{(32-RW){1'b0}}, ref_row_reg};
          `DDRPR_IDX_ERR: wb_dat_o <= {29'h00000000, err_reg};
          // unmapped words read zero and still ack
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // writable config registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= `DDRPR_CFG_RST;
      tim_reg <= `DDRPR_TIM_RST;
    end else if (wb_req && wb_we_i && wb_ack_o) begin
      if (widx == `DDRPR_IDX_CFG)
        cfg_reg <= (cfg_reg & ~wmask[10:0]) | (wb_dat_i[10:0] & wmask[10:0]);
      if (widx == `DDRPR_IDX_TIM)
        tim_reg <= (tim_reg & ~wmask[27:0]) | (wb_dat_i[27:0] & wmask[27:0]);
    end
  end

  // sticky protocol errors seen from the pins; a new event wins
  // over a write-one-to-clear in the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_reg <= 3'h0;
    end else begin
      if (wb_req && wb_we_i && wb_ack_o && widx == `DDRPR_IDX_ERR)
        err_reg <= (err_reg & ~(wb_dat_i[2:0] & wmask[2:0])) |
          {(is_act | is_rd | is_wr | is_pre | is_ref) &
            (xp_cnt_reg != 4'h0),
           ck_rise & pstate_reg[0] & cke_prev_reg & ~cke_s &
            (burst_cnt_reg != 5'h00),
           is_ref & ~all_idle};
      else
        err_reg <= err_reg |
          {(is_act | is_rd | is_wr | is_pre | is_ref) &
            (xp_cnt_reg != 4'h0),
           ck_rise & pstate_reg[0] & cke_prev_reg & ~cke_s &
            (burst_cnt_reg != 5'h00),
           is_ref & ~all_idle};
    end
  end
endmodule

// *** sim/ddrpr_props.sv ***
// port assertions for the ddr2 bank, refresh and power-down block
`timescale 1ns/1ps
module ddrpr_props #(
  parameter RW = 16
) (
  input wire clk,
  input wire nrst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire cke,
  input wire [7:0] bank_open,
  input wire dll_on,
  input wire pd_active,
  input wire cmd_ready
);
  // one clock domain, so clocking and reset are stated once
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // a taken request is answered exactly one cycle later
  chk_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acked in the next cycle");
  // ack is a single pulse even if strobe lingers
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // out of power-down the dll runs; [*3] covers the entry lag
  chk_dll_normal: assert property (
    !pd_active [*3] |-> dll_on)
    else $error("dll off outside power-down");
  // precharge power-down always stops the dll
  chk_dll_ppd: assert property (
    (pd_active && bank_open == 8'h00) [*3] |-> !dll_on)
    else $error("dll on in precharge power-down");
  // no command may be accepted while powered down
  chk_ready_pd: assert property (
    pd_active [*2] |-> !cmd_ready)
    else $error("command ready during power-down");
  // exit latency is at least one ck edge, far above 8 clk
  chk_exit_hold: assert property (
    $fell(pd_active) |-> !cmd_ready [*8])
    else $error("command ready too soon after exit");
  // but it does end within the longest programmable latency
  chk_exit_bound: assert property (
    $fell(pd_active) |-> ##[1:400] cmd_ready)
    else $error("command ready never returned after exit");
  // entry needs clock enable low well before, sync delay included
  chk_entry_cke: assert property (
    $rose(pd_active) |-> !$past(cke, 8))
    else $error("power-down entered with clock enable high");
  // exit needs clock enable high
  chk_exit_cke: assert property (
    $fell(pd_active) |-> $past(cke, 8))
    else $error("power-down left with clock enable low");
  // no row can open while the inputs are dead
  chk_no_open_pd: assert property (
    pd_active [*2] |-> (bank_open & ~$past(bank_open)) == 8'h00)
    else $error("bank opened during power-down");
endmodule

bind ddrpr_top ddrpr_props #(.RW(RW)) ddrpr_props_inst (
  .clk(clk),
  .nrst(nrst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .cke(cke),
  .bank_open(bank_open),
  .dll_on(dll_on),
  .pd_active(pd_active),
  .cmd_ready(cmd_ready)
);

// *** sim/ddrpr_ctl_model.sv ***
// ddr2 controller stand-in: link clock, clock enable and command pins
`timescale 1ns/1ps
module ddrpr_ctl_model (
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic a10,
  output logic [2:0] ba
);
  // nop with clock enable low, as after power-up
  initial begin
    ck = 1'b0;
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    a10 = 1'b0;
    ba = 3'h0;
  end
  // free-running link clock, kept stable through power-down
  always #40 ck = ~ck;
  // one command then nop; pins move on falling ck, stable at the rise
  task automatic issue(input logic [3:0] c, input logic a,
                       input logic [2:0] b, input int gap);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = c;
    a10 = a;
    ba = b;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    // released address is not held, so stale values cannot pass
    a10 = ~a;
    ba = ~b;
    repeat (gap) @(negedge ck);
  endtask
  // clock enable moves only with nop, then holds three edges
  task automatic set_cke(input logic v);
    @(negedge ck);
    cke = v;
    repeat (3) @(negedge ck);
  endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench for the ddr2 bank, refresh and power-down block
`timescale 1ns/1ps
module tb;
  localparam logic [3:0] C_ACT = 4'h3; // command codes cs,ras,cas,we
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_RD = 4'h5;
  localparam logic [3:0] C_WR = 4'h4;
  localparam logic [3:0] C_REF = 4'h1;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, ck, cke, cs_n, ras_n, cas_n, we_n, a10;
  wire [2:0] ba;
  wire [7:0] bank_open;
  wire dll_on, pd_active, cmd_ready;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000001a; // xorshift state
  logic [31:0] q; // read data of the last bus cycle
  logic [31:0] r0;
  logic [2:0] b;

  always #2 clk = ~clk;

  ddrpr_top #(.RW(16)) ddrpr_top_inst (.clk(clk), .nrst(nrst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ck(ck), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .a10(a10),
    .ba(ba), .bank_open(bank_open), .dll_on(dll_on),
    .pd_active(pd_active), .cmd_ready(cmd_ready));
  ddrpr_ctl_model ddrpr_ctl_model_inst (.ck(ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .a10(a10), .ba(ba));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // read-to-precharge cycles: analog time over clk period, rounded up
  function automatic logic [7:0] ru_cycles(input int ps, input int per);
    return (ps + per - 1) / per;
  endfunction

  task automatic close_out;
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; the master waits for ack, never a fixed count
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    cmp({31'h0, wb_ack_o}, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // let n link edges pass, then the pin synchroniser settle
  task automatic wait_ck(input int n);
    repeat (n) @(posedge ck);
    repeat (8) @(posedge clk);
  endtask

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    cmp({21'h0, bank_open, dll_on, pd_active, cmd_ready}, 32'h5);
    wb(1'b0, 8'h00, 32'h0);
    cmp(q & 32'h7ff, 32'h19c);
    wb(1'b0, 8'h04, 32'h0);
    cmp(q & 32'hfffffff, 32'h2040210);
    // unmapped and read-only places ignore writes
    wb(1'b1, 8'h3c, 32'hffffffff);
    wb(1'b0, 8'h3c, 32'h0);
    cmp(q, 32'h0);
    wb(1'b1, 8'h08, 32'hffffffff);
    wb(1'b0, 8'h08, 32'h0);
    cmp(q & 32'hff, 32'h0);
    ddrpr_ctl_model_inst.set_cke(1'b1);
    // plain read keeps the row open until an explicit precharge
    seed = xs(seed);
    b = seed[2:0];
    ddrpr_ctl_model_inst.issue(C_ACT, 1'b0, b, 2);
    ddrpr_ctl_model_inst.issue(C_RD, 1'b0, b, 8);
    cmp(bank_open, 32'h1 << b);
    ddrpr_ctl_model_inst.issue(C_PRE, 1'b0, b, 2);
    cmp(bank_open, 32'h0);
    // auto-precharge read and write, both burst lengths
    for (int bl = 0; bl < 2; bl++) begin
      wb(1'b1, 8'h00, 32'h19c | (bl << 6));
      for (int k = 0; k < 2; k++) begin
        seed = xs(seed);
        b = seed[2:0];
        ddrpr_ctl_model_inst.issue(C_ACT, 1'b0, b, 2);
        ddrpr_ctl_model_inst.issue(k ? C_WR : C_RD, 1'b1, b,
                                   (k ? 9 : 4) + 2 * bl);
        cmp(bank_open, 32'h1 << b);
        wait_ck(3);
        cmp(bank_open, 32'h0);
        wait_ck(8);
      end
    end
    wb(1'b1, 8'h00, 32'h19c);
    // long row-active minimum postpones the auto-precharge
    seed = xs(seed);
    r0 = 32'h2040000 | (32'd230 + seed % 21);
    r0 = r0 | ({24'h0, ru_cycles(6000, 4000)} << 8);
    wb(1'b1, 8'h04, r0);
    wb(1'b0, 8'h04, 32'h0);
    cmp(q & 32'hfffffff, r0);
    b = seed[6:4];
    ddrpr_ctl_model_inst.issue(C_ACT, 1'b0, b, 0);
    ddrpr_ctl_model_inst.issue(C_RD, 1'b1, b, 8);
    cmp(bank_open, 32'h1 << b);
    wait_ck(4);
    cmp(bank_open, 32'h0);
    wb(1'b1, 8'h04, 32'h2040210);
    // refresh advances the row counter only with every bank idle
    wb(1'b0, 8'h0c, 32'h0);
    r0 = q;
    ddrpr_ctl_model_inst.issue(C_REF, seed[7], seed[10:8], 4);
    wb(1'b0, 8'h0c, 32'h0);
    cmp(q & 32'hffff, (r0 + 1) & 32'hffff);
    ddrpr_ctl_model_inst.issue(C_ACT, 1'b0, b, 2);
    ddrpr_ctl_model_inst.issue(C_REF, 1'b0, 3'h0, 4);
    wb(1'b0, 8'h0c, 32'h0);
    cmp(q & 32'hffff, (r0 + 1) & 32'hffff);
    wb(1'b0, 8'h10, 32'h0);
    cmp(q & 32'h1, 32'h1);
    wb(1'b1, 8'h10, 32'h1);
    wb(1'b0, 8'h10, 32'h0);
    cmp(q & 32'h1, 32'h0);
    ddrpr_ctl_model_inst.issue(C_PRE, 1'b1, 3'h0, 2);
    cmp(bank_open, 32'h0);
    // precharge, fast-exit active and slow-exit active power-down
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, 8'h00, m == 2 ? 32'h59c : 32'h19c);
      if (m > 0) begin
        ddrpr_ctl_model_inst.issue(C_ACT, 1'b0, b, 2);
      end
      ddrpr_ctl_model_inst.set_cke(1'b0);
      cmp({pd_active, dll_on, cmd_ready}, m == 1 ? 3'b110 : 3'b100);
      wb(1'b0, 8'h08, 32'h0);
      cmp(q[18:16], 3'b001 << m);
      ddrpr_ctl_model_inst.set_cke(1'b1);
      wait_ck(1);
      cmp({pd_active, dll_on, cmd_ready}, 3'b011);
      if (m > 0) begin
        ddrpr_ctl_model_inst.issue(C_PRE, 1'b1, 3'h0, 2);
      end
    end
    close_out();
  end
endmodule
